// >>> rtl/dioip_defs.svh
// constants for the digital i/o interrupt port: offsets, fields, resets
// assumes: included by bare name from the package and the checker
`ifndef DIOIP_DEFS_SVH
`define DIOIP_DEFS_SVH

// register byte offsets inside the 32-byte block
`define DIOIP_OFF_IN 5'h00
`define DIOIP_OFF_OUT 5'h04
`define DIOIP_OFF_IEN 5'h08
`define DIOIP_OFF_EDGE 5'h0C
`define DIOIP_OFF_STAT 5'h10
`define DIOIP_OFF_FILT 5'h14
`define DIOIP_OFF_BASE 5'h18

// block decode: byte address bits above the block
`define DIOIP_BLK_MSB 31
`define DIOIP_BLK_LSB 5
`define DIOIP_BASE_RST 27'h0000000

// widths and reset values
`define DIOIP_NCH 32
`define DIOIP_ZERO32 32'h00000000
// idle pin level: pulled-up input, logic zero after the inversion
`define DIOIP_ONES32 32'hFFFFFFFF
`define DIOIP_FILT_W 8
`define DIOIP_FILT_RST 8'h00
`define DIOIP_FCNT_RST 8'h00
`define DIOIP_FCNT_ONE 8'h01

`endif

// >>> rtl/dioip_pkg.sv
// types shared by the digital i/o interrupt port modules
// assumes: the defs header sits in the include path
package dioip_pkg;
  `include "dioip_defs.svh"

  // apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dioip_apb_req_t;

  // software-owned configuration
  typedef struct packed {
    logic [31:0] out_data;
    logic [31:0] irq_en;
    logic [31:0] edge_sel;
    logic [7:0] filt;
    logic [26:0] base;
  } dioip_cfg_t;
endpackage : dioip_pkg

// >>> rtl/dioip_filter.sv
// digital filter for all inputs: a bit follows the pin only after it has
// held a new level for the programmed number of sample ticks
// assumes: inputs already synchronised to clk_i
`timescale 1ns/100ps
module dioip_filter
  import dioip_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] raw_i, // logic-level, synchronised inputs
  input wire logic [7:0] filt_i, // 0 passes the input straight through
  output logic [31:0] clean_o // filtered value
);

  logic [7:0] cnt [0:31]; // per-channel stability counters
  logic [7:0] next_cnt [0:31];
  logic [31:0] clean;
  logic [31:0] next_clean;

  assign clean_o = clean;

  ////////////////////////////////////////////////////////////////////////////
  // next state: a counter per channel, restarted whenever pin equals output
  always_comb begin
    for (int i = 0; i < `DIOIP_NCH; i++) begin
      next_cnt[i] = cnt[i];
      next_clean[i] = clean[i];
      if (filt_i == `DIOIP_FILT_RST) begin
        // filter off: one cycle of latency only
        next_clean[i] = raw_i[i];
        next_cnt[i] = `DIOIP_FCNT_RST;
      end else if (raw_i[i] == clean[i]) begin
        // chatter resets the wait
        next_cnt[i] = `DIOIP_FCNT_RST;
      end else if (cnt[i] + `DIOIP_FCNT_ONE >= filt_i) begin
        next_clean[i] = raw_i[i];
        next_cnt[i] = `DIOIP_FCNT_RST;
      end else begin
        next_cnt[i] = cnt[i] + `DIOIP_FCNT_ONE;
      end
    end
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clean <= `DIOIP_ZERO32;
      for (int i = 0; i < `DIOIP_NCH; i++) begin
        cnt[i] <= `DIOIP_FCNT_RST;
      end
    end else begin
      clean <= next_clean;
      for (int i = 0; i < `DIOIP_NCH; i++) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end
endmodule : dioip_filter

// >>> rtl/dioip_edge.sv
// per-bit edge detector on filtered logic-level inputs
// assumes: input comes from flip-flops on clk_i
`timescale 1ns/100ps
module dioip_edge
  import dioip_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] level_i, // filtered logic-level inputs
  input wire logic [31:0] edge_sel_i, // 1 = logical fall, 0 = logical rise
  output logic [31:0] event_o // one-cycle pulse per selected edge
);

  logic [31:0] prev; // level one cycle ago
  logic [31:0] next_prev;

  ////////////////////////////////////////////////////////////////////////////
  // rise = 0->1 logic (pin high to low); fall = 1->0 logic (pin low to high)
  always_comb begin
    next_prev = level_i;
    event_o = (edge_sel_i & prev & ~level_i) |
              (~edge_sel_i & ~prev & level_i);
  end

  // registers only; reset to zero so a pin held low at release
  // gives one logical rise, which a masked bit hides anyway
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= `DIOIP_ZERO32;
    end else begin
      prev <= next_prev;
    end
  end
endmodule : dioip_edge

// >>> rtl/dioip_top.sv
// digital i/o interrupt port: 32 inputs, 32 open-collector outputs, apb
// register slave, per-bit edge interrupts merged onto one level line
// assumes: apb master on clk_i; pins are asynchronous to clk_i
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
module dioip_top
  import dioip_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [31:0] in_pin_i, // electrical input pin levels
  output logic [31:0] out_pin_o, // driven value: always low when enabled
  output logic [31:0] out_pin_oe_o, // high where the transistor is on
  output logic irq_o // level interrupt, high while pending
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  dioip_apb_req_t req; // bundled bus inputs
  dioip_cfg_t cfg; // configuration registers
  dioip_cfg_t next_cfg;
  logic [31:0] stat; // sticky interrupt status
  logic [31:0] next_stat;
  logic [31:0] sync_a; // first synchroniser stage, read by sync_b only
  logic [31:0] sync_b; // second stage
  logic [31:0] logic_in; // logic-level inputs before filtering
  logic [31:0] filt_in; // filtered logic-level inputs
  logic [31:0] events; // selected edge pulses
  logic [31:0] rdata; // registered read data
  logic [31:0] next_rdata;
  logic slverr;
  logic next_slverr;
  logic hit; // address within the block
  logic acc; // access phase of a transfer
  logic [4:0] off; // offset within the block

  assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i,
                 addr: paddr_i, wdata: pwdata_i};

  ////////////////////////////////////////////////////////////////////////////
  // input path: two flops, then inversion into logic levels
  always_ff @(posedge clk_i) begin
    // reset to the pulled-up idle level, so no false ones or edges follow
    if (rst_i) begin
      sync_a <= `DIOIP_ONES32;
      sync_b <= `DIOIP_ONES32;
    end else begin
      sync_a <= in_pin_i;
      sync_b <= sync_a;
    end
  end

  assign logic_in = ~sync_b;

  dioip_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(logic_in),
    .filt_i(cfg.filt),
    .clean_o(filt_in)
  );

  // every one of 32 inputs can raise an event
  dioip_edge u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(filt_in),
    .edge_sel_i(cfg.edge_sel),
    .event_o(events)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  // block match against software base
  function automatic logic in_block(input logic [31:0] a,
                                    input logic [26:0] b);
    in_block = (a[`DIOIP_BLK_MSB:`DIOIP_BLK_LSB] == b);
  endfunction : in_block

  always_comb begin
    hit = in_block(req.addr, cfg.base);
    acc = req.sel & req.enable;
    off = req.addr[`DIOIP_BLK_LSB-1:0];
  end

  // zero wait states: pready stays high, answer in the first access cycle
  assign pready_o = 1'b1;
  assign prdata_o = rdata;
  assign pslverr_o = slverr;

  ////////////////////////////////////////////////////////////////////////////
  // register next values
  always_comb begin
    next_cfg = cfg;
    next_stat = stat;
    next_rdata = rdata;
    next_slverr = 1'b0;
    // software clear first: write one to clear
    if (acc && req.write && hit && off == `DIOIP_OFF_STAT) begin
      next_stat = stat & ~req.wdata;
    end
    // only the selected edge sets status
    next_stat = next_stat | (events & cfg.irq_en);
    // setup phase prepares read data so it is valid in the access phase
    if (req.sel && !req.enable && !req.write) begin
      unique case (off)
        `DIOIP_OFF_IN: next_rdata = filt_in;
        `DIOIP_OFF_OUT: next_rdata = cfg.out_data;
        `DIOIP_OFF_IEN: next_rdata = cfg.irq_en;
        `DIOIP_OFF_EDGE: next_rdata = cfg.edge_sel;
        `DIOIP_OFF_STAT: next_rdata = stat;
        `DIOIP_OFF_FILT: next_rdata = {24'h000000, cfg.filt};
        `DIOIP_OFF_BASE: next_rdata = {cfg.base, 5'h00};
        default: next_rdata = `DIOIP_ZERO32;
      endcase
      // outside the block reads as zero
      if (!hit) begin
        next_rdata = `DIOIP_ZERO32;
      end
    end
    // writes take effect at the access edge
    if (acc && req.write && hit) begin
      unique case (off)
        `DIOIP_OFF_OUT: next_cfg.out_data = req.wdata;
        `DIOIP_OFF_IEN: next_cfg.irq_en = req.wdata;
        `DIOIP_OFF_EDGE: next_cfg.edge_sel = req.wdata;
        `DIOIP_OFF_FILT: next_cfg.filt = req.wdata[`DIOIP_FILT_W-1:0];
        `DIOIP_OFF_BASE:
          next_cfg.base = req.wdata[`DIOIP_BLK_MSB:`DIOIP_BLK_LSB];
        default: next_cfg = cfg; // input and status: no config effect
      endcase
    end
    // unmapped offset inside the block flags an error; outside is ignored
    if (req.sel && !req.enable && hit) begin
      next_slverr = (off > `DIOIP_OFF_BASE) || (off[1:0] != 2'b00);
    end else if (acc) begin
      next_slverr = slverr;
    end
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= '{out_data: `DIOIP_ZERO32, irq_en: `DIOIP_ZERO32,
               edge_sel: `DIOIP_ZERO32, filt: `DIOIP_FILT_RST,
               base: `DIOIP_BASE_RST};
      stat <= `DIOIP_ZERO32;
      rdata <= `DIOIP_ZERO32;
      slverr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      stat <= next_stat;
      rdata <= next_rdata;
      slverr <= next_slverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // open-collector, one turns the transistor on
  assign out_pin_o = `DIOIP_ZERO32;
  assign out_pin_oe_o = cfg.out_data;

  // single level request from all pending sources
  assign irq_o = |(stat & cfg.irq_en);
endmodule : dioip_top

// >>> tb/dioip_top_sva.sv
// checker for the i/o port: apb slave, output pins, interrupt line
// assumes: bound to dioip_top; base copy follows in-block base writes
`timescale 1ns/100ps
`include "dioip_defs.svh"
module dioip_top_sva (
  input wire logic clk_i, rst_i, psel_i, penable_i, pwrite_i,
  input wire logic [31:0] paddr_i, pwdata_i, prdata_o, in_pin_i,
  input wire logic [31:0] out_pin_o, out_pin_oe_o,
  input wire logic pready_o, pslverr_o, irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [26:0] base; // shadow of the block base
  wire acc = psel_i && penable_i; // access phase
  wire blk = paddr_i[31:5] == base; // inside the block
  wire wr = acc && pwrite_i && blk;
  wire [4:0] off = paddr_i[4:0];
  // shadow base, same reset as the slave
  always_ff @(posedge clk_i) begin
    if (rst_i) base <= 27'h0000000;
    else if (wr && off == `DIOIP_OFF_BASE) base <= pwdata_i[31:5];
  end
  property p_rdy; pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_pin; out_pin_o == 32'h00000000; endproperty
  a_pin: assert property (p_pin) else $error("pin driven high");
  property p_owr; wr && off == `DIOIP_OFF_OUT |=> out_pin_oe_o == $past(pwdata_i);
  endproperty
  a_owr: assert property (p_owr) else $error("oe not written");
  property p_ohld; !$past(wr) |-> $stable(out_pin_oe_o); endproperty
  a_ohld: assert property (p_ohld) else $error("oe moved");
  property p_err;
    acc |-> pslverr_o == (blk && (off > 5'h18 || off[1:0] != 2'h0));
  endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_rz; acc && !pwrite_i && !blk |-> prdata_o == 32'h00000000;
  endproperty
  a_rz: assert property (p_rz) else $error("outside read");
  property p_ifall; $fell(irq_o) |-> $past(wr); endproperty
  a_ifall: assert property (p_ifall) else $error("irq dropped");
  property p_rst; disable iff (1'b0) rst_i |=> !irq_o && out_pin_oe_o == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  cover property ($rose(irq_o));
  cover property (acc && pslverr_o);
  cover property (wr && off == `DIOIP_OFF_BASE);
endmodule : dioip_top_sva
bind dioip_top dioip_top_sva dioip_top_sva_inst (.clk_i(clk_i),
  .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .in_pin_i(in_pin_i), .out_pin_o(out_pin_o),
  .out_pin_oe_o(out_pin_oe_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .irq_o(irq_o));

// >>> tb/dioip_field.sv
// field side: switches to common on inputs, pull-ups on the outputs
// assumes: sw_i one means the switch is closed
`timescale 1ns/100ps
module dioip_field (
  input wire logic [31:0] sw_i,
  input wire logic [31:0] drv_i,
  input wire logic [31:0] oe_i,
  output logic [31:0] in_pin_o,
  output logic [31:0] line_o
);
  assign in_pin_o = ~sw_i;
  assign line_o = (oe_i & drv_i) | ~oe_i;
endmodule : dioip_field

// >>> tb/test_digital_io_interrupt_port.sv
// bench for the i/o port: apb master, field model, random stimulus
// assumes: checker bound to the top; base starts at zero
`timescale 1ns/100ps
module test_digital_io_interrupt_port;
  logic clk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, oe, outp, line, pin;
  logic [31:0] sw = 0, rd, m, ov;
  logic pready, perr, err, irq;
  int n_mismatch = 0, checks = 0;
  always #20 clk_i = ~clk_i;
  dioip_top dioip_top_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .in_pin_i(pin), .out_pin_o(outp), .out_pin_oe_o(oe), .irq_o(irq));
  dioip_field dioip_field_inst (.sw_i(sw), .drv_i(outp), .oe_i(oe),
    .in_pin_o(pin), .line_o(line));
  task chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // one apb transfer, held until pready is seen
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge clk_i);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    pen <= 1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 0; pen <= 0;
  endtask : apb
  task pause(input int n);
    repeat (n) @(posedge clk_i);
  endtask : pause
  initial begin
    pause(5000);
    n_mismatch++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h78d22485));
    pause(4);
    rst_i <= 0;
    for (int o = 0; o < 28; o += 4) begin
      apb(0, 32'(o), 0); chk("reset", rd, 0);
    end
    ov = $urandom();
    apb(1, 32'h04, ov); apb(0, 32'h04, 0); chk("out", rd, ov);
    chk("oe", oe, ov); chk("line", line, ~ov);
    m = $urandom(); sw <= m; pause(6);
    apb(0, 32'h00, 0); chk("in", rd, m);
    for (int e = 0; e < 2; e++) begin
      sw <= 0; pause(6);
      m = $urandom();
      apb(1, 32'h10, '1); apb(1, 32'h0C, {32{e[0]}}); apb(1, 32'h08, m);
      sw <= '1; pause(6);
      apb(0, 32'h10, 0); chk("rise", rd, e ? 0 : m);
      sw <= 0; pause(6);
      apb(0, 32'h10, 0); chk("stat", rd, m);
      chk("irq", 32'(irq), 32'(m != 0));
      apb(1, 32'h10, m); apb(0, 32'h10, 0); chk("clr", rd, 0);
      chk("irq0", 32'(irq), 0);
    end
    apb(1, 32'h14, 4);
    sw[0] <= 1; pause(2); sw[0] <= 0; pause(10);
    apb(0, 32'h00, 0); chk("glitch", rd, 0);
    sw[0] <= 1; pause(12);
    apb(0, 32'h00, 0); chk("held", rd, 1);
    apb(1, 32'h18, 32'h00000400); apb(1, 32'h04, 0);
    chk("old", oe, ov); apb(0, 32'h04, 0); chk("oldrd", rd, 0);
    apb(1, 32'h404, ~ov); pause(1);
    chk("new", oe, ~ov);
    apb(0, 32'h41C, 0); chk("bad", 32'(err), 1);
    apb(1, 32'h406, 0); chk("odd", 32'(err), 1); chk("kept", oe, ~ov);
    stop_test();
  end
endmodule : test_digital_io_interrupt_port
